// [src/agcl_top.sv]
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
module agcl_top
(
	input  wire logic                          CLK_IN,
	input  wire logic                          SYS_RST_IN,
	// ahb-lite slave
	input  wire logic                          HSEL_IN,
	input  wire logic [31:0]                   HADDR_IN,
	input  wire logic [1:0]                    HTRANS_IN,
	input  wire logic                          HWRITE_IN,
	input  wire logic [2:0]                    HSIZE_IN,
	input  wire logic [31:0]                   HWDATA_IN,
	input  wire logic                          HREADY_IN,
	output logic [31:0]                        HRDATA_OUT,
	output logic                               HREADYOUT_OUT,
	output logic                               HRESP_OUT,
	// filter result in, scaled result out
	input  wire logic signed [agcl_pkg::IN_W-1:0]  FIR_I_IN,
	input  wire logic signed [agcl_pkg::IN_W-1:0]  FIR_Q_IN,
	input  wire logic                          FIR_VALID_IN,
	output logic signed [agcl_pkg::OUT_W-1:0]  GAIN_I_OUT,
	output logic signed [agcl_pkg::OUT_W-1:0]  GAIN_Q_OUT,
	output logic                               GAIN_VALID_OUT,
	// interpolated samples back from the resampler
	input  wire logic signed [agcl_pkg::FB_W-1:0]  FB_I_IN,
	input  wire logic signed [agcl_pkg::FB_W-1:0]  FB_Q_IN,
	input  wire logic                          FB_VALID_IN,
	output logic                               FB_READY_OUT,
	output logic [agcl_pkg::MAG_W-1:0]         MAG_OUT,
	output logic [15:0]                        PHASE_OUT,
	output logic                               MAG_VALID_OUT,
	input  wire logic                          LOOP_GAIN_SET_SELECT_IN
);
	import agcl_pkg::*;

	logic [THR_W-1:0]          thr_reg;
	logic [15:0]               gs_reg;
	logic [LIM_W-1:0]          lim_hi_reg;
	logic [LIM_W-1:0]          lim_lo_reg;
	logic                      wr_pend_reg;
	logic [7:0]                wr_idx_reg;
	logic [31:0]               rdata_reg;
	logic [ACC_W-1:0]          acc_reg;
	logic [ACC_W-1:0]          acc_next;
	logic                      addr_ok;
	logic                      mapped;
	logic [7:0]                a_idx;
	logic [31:0]               cw8_img;
	logic [31:0]               cw9_img;
	logic [31:0]               rd_mux;
	logic [EXP_W-1:0]          g_exp;
	logic [MANT_W-1:0]         g_mant;
	logic [LG_W-1:0]           lg_m;
	logic [LG_W-1:0]           lg_e;
	logic signed [12:0]        err;
	logic signed [17:0]        prod;
	logic signed [ACC_W+1:0]   inc;
	logic signed [ACC_W+1:0]   sum;
	logic signed [ACC_W+1:0]   lo_ext;
	logic signed [ACC_W+1:0]   hi_ext;
	logic signed [ACC_W+1:0]   t;
	logic [MAG_W-1:0]          mag;
	logic                      mag_valid;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	// zero wait states, every transfer answered okay
	assign HREADYOUT_OUT = 1'b1;
	assign HRESP_OUT     = 1'b0;
	assign HRDATA_OUT    = rdata_reg;

	assign addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1];
	assign a_idx   = HADDR_IN[9:2];
	assign mapped  = (HADDR_IN[31:10] == 22'h0) && (HADDR_IN[1:0] == 2'h0);

	// register images; a write in its data phase is forwarded so a read right behind it sees new data
	always_comb begin
		cw8_img = {3'h0, 1'b0, thr_reg, gs_reg}; // RL12
		cw9_img = {4'h0, lim_hi_reg, 4'h0, lim_lo_reg}; // RL19
		if (wr_pend_reg && wr_idx_reg == CW8_IDX) begin
			cw8_img = {4'h0, HWDATA_IN[THR_LSB+THR_W-1:THR_LSB], HWDATA_IN[15:0]};
		end
		if (wr_pend_reg && wr_idx_reg == CW9_IDX) begin
			cw9_img = {4'h0, HWDATA_IN[LIM_HI_LSB+LIM_W-1:LIM_HI_LSB], 4'h0,
				HWDATA_IN[LIM_LO_LSB+LIM_W-1:LIM_LO_LSB]};
		end
		rd_mux = 32'h0;
		if (mapped) begin
			case (a_idx)
				CW8_IDX:  rd_mux = cw8_img;
				CW9_IDX:  rd_mux = cw9_img;
				STAT_IDX: rd_mux = {12'h0, g_exp, g_mant};
				default:  rd_mux = 32'h0;
			endcase
		end
	end

	// address phase capture; narrow writes are dropped
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 8'h0;
			rdata_reg   <= 32'h0;
		end else begin
			wr_pend_reg <= addr_ok && HWRITE_IN && mapped && (HSIZE_IN == SIZE_WORD);
			wr_idx_reg  <= a_idx;
			if (addr_ok && !HWRITE_IN) begin
				rdata_reg <= rd_mux;
			end
		end
	end

	// configuration words written in the data phase
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			thr_reg    <= THR_RST;
			gs_reg     <= GS_RST;
			lim_hi_reg <= LIM_RST;
			lim_lo_reg <= LIM_RST;
		end else if (wr_pend_reg) begin
			if (wr_idx_reg == CW8_IDX) begin
				thr_reg <= HWDATA_IN[THR_LSB+THR_W-1:THR_LSB]; // RL12 RL13
				gs_reg  <= HWDATA_IN[15:0];
			end
			if (wr_idx_reg == CW9_IDX) begin
				lim_hi_reg <= HWDATA_IN[LIM_HI_LSB+LIM_W-1:LIM_HI_LSB]; // RL19
				lim_lo_reg <= HWDATA_IN[LIM_LO_LSB+LIM_W-1:LIM_LO_LSB]; // RL19
			end
		end
	end

	// ----------------------------------------
	// forward path: multiplier and shifter per channel
	// ----------------------------------------
	// gain code split: exponent on top, 16-bit mantissa below
	assign g_exp  = acc_reg[ACC_W-1:ACC_FRAC]; // RL20
	assign g_mant = acc_reg[ACC_FRAC-1:ACC_FRAC-MANT_W]; // RL20 RL9

	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic signed [OUT_W-1:0] ch_out;
		logic                    ch_vld;
		agcl_mulshift #(
			.IN_W   (IN_W),
			.OUT_W  (OUT_W),
			.MANT_W (MANT_W),
			.EXP_W  (EXP_W)
		) u_ms (
			.clk_in    (CLK_IN),
			.rst_in    (SYS_RST_IN),
			.data_in   ((c == 0) ? FIR_I_IN : FIR_Q_IN), // RL2
			.valid_in  (FIR_VALID_IN),
			.exp_in    (g_exp), // RL4
			.mant_in   (g_mant),
			.data_out  (ch_out),
			.valid_out (ch_vld)
		);
	end

	// each channel saturates on its own
	assign GAIN_I_OUT     = g_ch[0].ch_out; // RL6
	assign GAIN_Q_OUT     = g_ch[1].ch_out;
	assign GAIN_VALID_OUT = g_ch[0].ch_vld && g_ch[1].ch_vld;

	// ----------------------------------------
	// feedback: polar converter
	// ----------------------------------------
	agcl_cordic #(
		.FB_W  (FB_W),
		.MAG_W (MAG_W),
		.ITER  (CORDIC_ITER)
	) u_cordic (
		.clk_in    (CLK_IN),
		.rst_in    (SYS_RST_IN),
		.i_in      (FB_I_IN), // RL3
		.q_in      (FB_Q_IN),
		.valid_in  (FB_VALID_IN),
		.ready_out (FB_READY_OUT),
		.mag_out   (mag),
		.phase_out (PHASE_OUT),
		.valid_out (mag_valid)
	);
	assign MAG_OUT       = mag;
	assign MAG_VALID_OUT = mag_valid;

	// ----------------------------------------
	// error detector, scaler, loop filter
	// ----------------------------------------
	// error weight 1.0 moves the gain by 1.5dB, a quarter of one exponent step
	always_comb begin
		lg_m   = LOOP_GAIN_SET_SELECT_IN ? gs_reg[GS1_LSB+3:GS1_LSB] : gs_reg[GS0_LSB+3:GS0_LSB]; // RL18
		lg_e   = LOOP_GAIN_SET_SELECT_IN ? gs_reg[GS1_LSB+7:GS1_LSB+4] : gs_reg[GS0_LSB+7:GS0_LSB+4];
		err    = $signed({1'b0, thr_reg}) - $signed({1'b0, mag}); // RL11 RL13
		prod   = err * $signed({1'b0, lg_m}); // RL17
		inc    = (ACC_W+2)'(prod) <<< lg_e; // RL17
		sum    = $signed({2'b00, acc_reg}) + (mag_valid ? inc : '0); // RL16 RL4
		lo_ext = $signed({2'b00, lim_lo_reg, {(ACC_W-LIM_W){1'b0}}});
		hi_ext = $signed({2'b00, lim_hi_reg, {(ACC_W-LIM_W){1'b0}}});
		t      = (sum < lo_ext) ? lo_ext : sum; // RL16
		t      = (t > hi_ext) ? hi_ext : t; // RL16 RL14
		acc_next = t[ACC_W-1:0];
	end

	// clamps every cycle so new limits take hold without waiting for a sample
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			acc_reg <= '0;
		end else begin
			acc_reg <= acc_next; // RL16
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_BUS_OKAY: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		HREADYOUT_OUT && !HRESP_OUT)
		else $error("slave left zero-wait okay");
	AST_ACC_HI: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RL16
		1'b1 |=> {2'b00, acc_reg} <= $past(hi_ext))
		else $error("gain above upper limit");
	AST_ACC_LO: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RL16
		lim_lo_reg <= lim_hi_reg |=> {2'b00, acc_reg} >= $past(lo_ext))
		else $error("gain below lower limit");
	AST_FIXED: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RL14
		lg_m == 0 && !wr_pend_reg && {2'b00, acc_reg} <= hi_ext
			&& {2'b00, acc_reg} >= lo_ext |=> $stable(acc_reg))
		else $error("gain moved with zero loop gain");
	AST_DIR: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RL11
		mag_valid && mag > thr_reg && !wr_pend_reg && {2'b00, acc_reg} <= hi_ext
			&& {2'b00, acc_reg} >= lo_ext |=> acc_reg <= $past(acc_reg))
		else $error("gain rose while magnitude above target");
	AST_PASS: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RL2
		FIR_VALID_IN |=> GAIN_VALID_OUT)
		else $error("scaled sample not delivered next cycle");
	AST_THR_RZ: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN) // RL12
		addr_ok && !HWRITE_IN && mapped && a_idx == CW8_IDX |=> !HRDATA_OUT[28])
		else $error("threshold top bit read nonzero");
endmodule

// [src/agcl_pkg.sv]
// Operation
// RL1: gain lifts small signals from the low bits of 26-bit words into 16 bits
// RL2: filter samples pass the multiplier and shifter before resampling filters
// RL3: interpolated I and Q feed the polar converter giving magnitude and phase
// RL4: magnitude, error detector, error scaler, loop filter, then gain of the stage
// RL5: gain is taken when each sample enters; never changes mid sample
// RL6: shifter or multiplier overflow saturates the output, I and Q separately
// RL7: shifter gain is 2^N, N from 0 to 15, 6.021dB steps
// RL8: mantissa multiplier adds a factor one plus X, up to about 6dB
// RL9: gain mantissa carries 16 bits of resolution
// RL10: magnitude is 1.64676 times root of I squared plus Q squared
// RL11: error is threshold minus magnitude, feeding error scaling
// RL12: threshold sits in bits 16-28 of word 8, top bit reads zero
// RL13: threshold and error detector cover 0 to +3.9995
// RL14: a fixed gain can be chosen by configuration
// RL15: software fixes gain by equal limits, or wide limits and zero loop gain
// RL16: loop filter accumulates scaled error, clamped between the gain limits
// RL17: error scaling by 4-bit mantissa in sixteenths, then shift 2^0 to 2^-15
// RL18: two loop gain sets stored; select input low picks 0, high picks 1
// RL19: word 9 holds upper limit in bits 16-27, lower in bits 0-11
// RL20: accumulator splits into shifter exponent (top) and mantissa (below)
package agcl_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int IN_W        = 26;
	localparam int OUT_W       = 16;
	localparam int FB_W        = 16;
	localparam int MANT_W      = 16;
	localparam int EXP_W       = 4;
	localparam int LIM_W       = 12;
	localparam int THR_W       = 12;
	localparam int MAG_W       = 12;
	localparam int LG_W        = 4;
	localparam int ACC_W       = 35;
	localparam int ACC_FRAC    = 31;
	localparam int CORDIC_ITER = 16;

	// ----------------------------------------
	// register map: word index, byte address is four times it
	// ----------------------------------------
	localparam logic [7:0] CW8_IDX  = 8'h08;
	localparam logic [7:0] CW9_IDX  = 8'h09;
	localparam logic [7:0] STAT_IDX = 8'h0A;
	localparam int THR_LSB    = 16;
	localparam int GS0_LSB    = 0;
	localparam int GS1_LSB    = 8;
	localparam int LIM_HI_LSB = 16;
	localparam int LIM_LO_LSB = 0;
	localparam logic [THR_W-1:0] THR_RST  = 12'h000;
	localparam logic [15:0]      GS_RST   = 16'h0000;
	localparam logic [LIM_W-1:0] LIM_RST  = 12'h000;
	localparam logic [2:0]       SIZE_WORD = 3'h2;

	// ----------------------------------------
	// converter states
	// ----------------------------------------
	typedef enum logic [1:0] {
		AGCL_IDLE = 2'b01,
		AGCL_RUN  = 2'b10
	} agcl_cordic_st_t;

endpackage

// [src/agcl_mulshift.sv]
`timescale 1ns/100ps
module agcl_mulshift #(
	parameter int IN_W   = 26,
	parameter int OUT_W  = 16,
	parameter int MANT_W = 16,
	parameter int EXP_W  = 4
) (
	input  wire logic                     clk_in,
	input  wire logic                     rst_in,
	input  wire logic signed [IN_W-1:0]   data_in,
	input  wire logic                     valid_in,
	input  wire logic [EXP_W-1:0]         exp_in,
	input  wire logic [MANT_W-1:0]        mant_in,
	output logic signed [OUT_W-1:0]       data_out,
	output logic                          valid_out
);
	localparam int PR_W = IN_W + MANT_W + 2;
	localparam int SH_W = PR_W + (1 << EXP_W) - 1;
	localparam int LO   = MANT_W + IN_W - OUT_W;

	logic signed [PR_W-1:0]       prod;
	logic signed [SH_W-1:0]       sh;
	logic [SH_W-LO-OUT_W:0]       top;
	logic                         ovf;
	logic signed [OUT_W-1:0]      sat_val;

	// ----------------------------------------
	// gain: 2^N times (1 + X/2^16), keep top 16 of 26 bits
	// ----------------------------------------
	always_comb begin
		prod    = data_in * $signed({2'b01, mant_in}); // RL8 RL9
		sh      = SH_W'(prod) <<< exp_in; // RL7
		top     = sh[SH_W-1:LO+OUT_W-1];
		ovf     = !((&top) || !(|top)); // RL6
		sat_val = sh[SH_W-1] ? {1'b1, {(OUT_W-1){1'b0}}} : {1'b0, {(OUT_W-1){1'b1}}};
	end

	// gain is only looked at in the cycle the sample enters
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			data_out  <= '0;
			valid_out <= 1'b0;
		end else begin
			valid_out <= valid_in;
			if (valid_in) begin
				data_out <= ovf ? sat_val : sh[LO+OUT_W-1:LO]; // RL5 RL6 RL1
			end
		end
	end

	AST_SAT_HI: assert property (@(posedge clk_in) disable iff (rst_in) // RL6
		valid_in && ovf && !sh[SH_W-1] |=> data_out == {1'b0, {(OUT_W-1){1'b1}}})
		else $error("positive overflow not saturated");
	AST_HOLD: assert property (@(posedge clk_in) disable iff (rst_in) // RL5
		!valid_in |=> $stable(data_out))
		else $error("output moved without a new sample");
	AST_UNITY: assert property (@(posedge clk_in) disable iff (rst_in) // RL1
		valid_in && exp_in == 0 && mant_in == 0 |=> data_out == $past(data_in[IN_W-1:IN_W-OUT_W]))
		else $error("unity gain did not pass top bits");
endmodule

// [src/agcl_cordic.sv]
`timescale 1ns/100ps
module agcl_cordic #(
	parameter int FB_W  = 16,
	parameter int MAG_W = 12,
	parameter int ITER  = 16
) (
	input  wire logic                    clk_in,
	input  wire logic                    rst_in,
	input  wire logic signed [FB_W-1:0]  i_in,
	input  wire logic signed [FB_W-1:0]  q_in,
	input  wire logic                    valid_in,
	output logic                         ready_out,
	output logic [MAG_W-1:0]             mag_out,
	output logic [15:0]                  phase_out,
	output logic                         valid_out
);
	import agcl_pkg::*;

	localparam logic [15:0] ATAN [16] = '{16'h2000, 16'h12E4, 16'h09FB, 16'h0511, 16'h028B, 16'h0146,
		16'h00A3, 16'h0051, 16'h0029, 16'h0014, 16'h000A, 16'h0005, 16'h0003, 16'h0001, 16'h0001, 16'h0000};

	agcl_cordic_st_t              st_reg;
	logic signed [FB_W+2:0]       x_reg;
	logic signed [FB_W+2:0]       y_reg;
	logic [15:0]                  z_reg;
	logic [3:0]                   k_reg;
	logic signed [FB_W+2:0]       x_next;
	logic signed [FB_W+2:0]       y_next;
	logic [15:0]                  z_next;

	assign ready_out = (st_reg == AGCL_IDLE);

	// ----------------------------------------
	// one vectoring micro-rotation per clock, gain 1.64676 falls out
	// ----------------------------------------
	always_comb begin
		if (!y_reg[FB_W+2]) begin
			x_next = x_reg + (y_reg >>> k_reg);
			y_next = y_reg - (x_reg >>> k_reg);
			z_next = z_reg + ATAN[k_reg];
		end else begin
			x_next = x_reg - (y_reg >>> k_reg);
			y_next = y_reg + (x_reg >>> k_reg);
			z_next = z_reg - ATAN[k_reg];
		end
	end

	// left half plane is folded by 180 deg first so x starts positive
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_reg    <= AGCL_IDLE;
			x_reg     <= '0;
			y_reg     <= '0;
			z_reg     <= '0;
			k_reg     <= '0;
			mag_out   <= '0;
			phase_out <= '0;
			valid_out <= 1'b0;
		end else begin
			valid_out <= 1'b0;
			case (st_reg)
				AGCL_IDLE: begin
					if (valid_in) begin
						x_reg  <= i_in[FB_W-1] ? -(FB_W+3)'(i_in) : (FB_W+3)'(i_in); // RL3
						y_reg  <= i_in[FB_W-1] ? -(FB_W+3)'(q_in) : (FB_W+3)'(q_in);
						z_reg  <= i_in[FB_W-1] ? 16'h8000 : 16'h0000;
						k_reg  <= '0;
						st_reg <= AGCL_RUN;
					end
				end
				AGCL_RUN: begin
					x_reg <= x_next;
					y_reg <= y_next;
					z_reg <= z_next;
					k_reg <= k_reg + 4'h1;
					if (k_reg == 4'(ITER - 1)) begin
						mag_out   <= x_next[FB_W:FB_W-MAG_W+1]; // RL10
						phase_out <= z_next; // RL3
						valid_out <= 1'b1;
						st_reg    <= AGCL_IDLE;
					end
				end
				default: st_reg <= AGCL_IDLE;
			endcase
		end
	end

	AST_MAG_TIME: assert property (@(posedge clk_in) disable iff (rst_in) // RL3
		valid_in && ready_out |-> ##17 valid_out)
		else $error("magnitude not ready on time after start");
	AST_MAG_ZERO: assert property (@(posedge clk_in) disable iff (rst_in) // RL10
		valid_in && ready_out && i_in == 0 && q_in == 0 |-> ##17 mag_out == 0)
		else $error("zero input gave nonzero magnitude");
endmodule

// [tb/agcl_fir_src.sv]
`timescale 1ns/100ps
// ----------------------------------------
// upstream filter output model
// ----------------------------------------
module agcl_fir_src
	import agcl_pkg::*;
(
	input  wire logic                         clk_in,
	output logic signed [agcl_pkg::IN_W-1:0]  fir_i_out,
	output logic signed [agcl_pkg::IN_W-1:0]  fir_q_out,
	output logic                              fir_valid_out
);
	// quiet bus until the first sample
	initial begin
		fir_i_out     = '0;
		fir_q_out     = '0;
		fir_valid_out = 1'b0;
	end

	// one sample, i and q together; data scrambled after the valid cycle so stale values never pass
	task automatic send(input logic signed [IN_W-1:0] i, input logic signed [IN_W-1:0] q);
		@(posedge clk_in);
		fir_i_out     <= i;
		fir_q_out     <= q;
		fir_valid_out <= 1'b1;
		@(posedge clk_in);
		fir_i_out     <= ~i;
		fir_q_out     <= ~q;
		fir_valid_out <= 1'b0;
	endtask
endmodule

// [tb/auto_gain_control_loop_tb_top.sv]
`timescale 1ns/100ps
module auto_gain_control_loop_tb_top;
	import agcl_pkg::*;
	logic                      clk, rst, hsel, hwrite, fb_v, sel;
	logic [31:0]               haddr, hwdata, rd;
	logic [1:0]                htrans;
	logic [2:0]                hsize;
	logic signed [FB_W-1:0]    fb_i, fb_q;
	wire logic [31:0]          hrdata;
	wire logic                 hready, hresp, g_v, fb_rdy, mag_v, fir_v;
	wire logic signed [IN_W-1:0]  fir_i, fir_q;
	wire logic signed [OUT_W-1:0] g_i, g_q;
	wire logic [MAG_W-1:0]     mag;
	wire logic [15:0]          ph;
	int                        n_errors, samples_checked, cyc;

	agcl_fir_src src (.clk_in(clk), .fir_i_out(fir_i), .fir_q_out(fir_q), .fir_valid_out(fir_v));
	agcl_top uut (.CLK_IN(clk), .SYS_RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
		.HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
		.HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .FIR_I_IN(fir_i), .FIR_Q_IN(fir_q), .FIR_VALID_IN(fir_v),
		.GAIN_I_OUT(g_i), .GAIN_Q_OUT(g_q), .GAIN_VALID_OUT(g_v), .FB_I_IN(fb_i), .FB_Q_IN(fb_q),
		.FB_VALID_IN(fb_v), .FB_READY_OUT(fb_rdy), .MAG_OUT(mag), .PHASE_OUT(ph), .MAG_VALID_OUT(mag_v),
		.LOOP_GAIN_SET_SELECT_IN(sel));

	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			test_done();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic test_done();
		$display("checks=%0d mismatches=%0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// converter output is approximate, so allow a few lsb
	task automatic chk_near(input logic [31:0] got, input int exp, input int tol);
		samples_checked++;
		if ($isunknown(got) || int'(got) > exp + tol || int'(got) < exp - tol) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// single word transfers; hold each phase until hready is seen high
	task automatic ahb_wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		haddr  <= a;
		hwrite <= 1'b1;
		htrans <= 2'b10;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
	endtask
	task automatic ahb_rd(input logic [31:0] a);
		@(posedge clk);
		haddr  <= a;
		hwrite <= 1'b0;
		htrans <= 2'b10;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	// expected scaled sample: x * 2^e * (1 + m/65536), top 16 of 26 bits, saturated
	function automatic logic [15:0] fwd(input logic signed [IN_W-1:0] x, input int e, input int m);
		longint p;
		p = (longint'(x) * (65536 + m)) <<< e;
		p = p >>> 26;
		if (p > 32767) return 16'h7FFF;
		if (p < -32768) return 16'h8000;
		return p[15:0];
	endfunction
	task automatic fwd_t(input logic signed [IN_W-1:0] i, input logic signed [IN_W-1:0] q, input int e,
		input int m);
		src.send(i, q);
		#1;
		chk({31'h0, g_v}, 32'h1);
		chk({16'h0, g_i}, {16'h0, fwd(i, e, m)});
		chk({16'h0, g_q}, {16'h0, fwd(q, e, m)});
	endtask
	// feedback sample; converter answers exactly 16 edges after acceptance
	task automatic fb_send(input logic signed [FB_W-1:0] i, input logic signed [FB_W-1:0] q);
		int n;
		@(posedge clk);
		fb_i <= i;
		fb_q <= q;
		fb_v <= 1'b1;
		do @(posedge clk); while (fb_rdy !== 1'b1);
		fb_v <= 1'b0;
		fb_i <= ~i;
		fb_q <= ~q;
		n = 0;
		#1 chk({31'h0, fb_rdy}, 32'h0);
		while (mag_v !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1 n++;
		end
		chk(n, 16);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		hsel = 1'b1;
		hwrite = 1'b0;
		haddr = '0;
		hwdata = '0;
		htrans = 2'b00;
		hsize = SIZE_WORD;
		fb_i = '0;
		fb_q = '0;
		fb_v = 1'b0;
		sel = 1'b0;
		n_errors = 0;
		samples_checked = 0;
		cyc = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// reset state and bus response
		#1 chk({30'h0, hready, hresp}, 32'h2);
		chk({31'h0, fb_rdy}, 32'h1);
		ahb_rd(32'h28); chk(rd, 32'h0);
		ahb_rd(32'h20); chk(rd, 32'h0);
		ahb_rd(32'h24); chk(rd, 32'h0);
		$display("reset values done");
		// field widths, read-only status, unmapped place
		ahb_wr(32'h20, 32'hFFFF_FFFF);
		ahb_rd(32'h20); chk(rd, 32'h0FFF_FFFF);
		// narrow writes are ignored
		hsize <= 3'h0;
		ahb_wr(32'h20, 32'h0);
		hsize <= SIZE_WORD;
		ahb_rd(32'h20); chk(rd, 32'h0FFF_FFFF);
		ahb_wr(32'h24, 32'hFFFF_FFFF);
		ahb_rd(32'h24); chk(rd, 32'h0FFF_0FFF);
		ahb_wr(32'h28, 32'h0);
		ahb_rd(32'h28); chk(rd, 32'h000F_FF00);
		ahb_wr(32'h100, 32'hFFFF_FFFF);
		ahb_rd(32'h100); chk(rd, 32'h0);
		$display("register map done");
		// unity gain: top 16 of the 26 bits
		ahb_wr(32'h20, 32'h0);
		ahb_wr(32'h24, 32'h0);
		ahb_rd(32'h28); chk(rd, 32'h0);
		fwd_t(26'h123_4567, 26'h2AB_CDEF, 0, 0);
		fwd_t(26'h000_03FF, 26'h3FF_FC00, 0, 0);
		$display("unity gain done");
		// fixed gain through equal limits, exp 3 mantissa 0x8000
		ahb_wr(32'h24, 32'h0380_0380);
		ahb_rd(32'h28); chk(rd, 32'h0003_8000);
		fwd_t(26'h000_1000, 26'h0FF_FFFF, 3, 32768);
		fwd_t(26'h300_0000, 26'h3FF_F000, 3, 32768);
		fwd_t(26'h000_0001, 26'h000_7FFF, 3, 32768);
		$display("fixed gain done");
		// closed loop: set0 zero gain, set1 full gain, threshold 1.0
		ahb_wr(32'h24, 32'h0FFF_0000);
		ahb_wr(32'h20, 32'h0400_FF00);
		fb_send(16'h0000, 16'h0000);
		ahb_rd(32'h28); chk(rd, 32'h0003_8000);
		sel <= 1'b1;
		fb_send(16'h0000, 16'h0000);
		ahb_rd(32'h28); chk(rd, 32'h0003_BC00);
		sel <= 1'b0;
		fb_send(16'h0000, 16'h4000);
		chk_near({20'h0, mag}, 843, 2);
		chk_near({16'h0, ph}, 16384, 4);
		ahb_rd(32'h28); chk(rd, 32'h0003_BC00);
		// left half plane is folded, still zero loop gain
		fb_send(16'hC000, 16'h0000);
		chk_near({20'h0, mag}, 843, 2);
		chk_near({16'h0, ph}, 32768, 4);
		ahb_rd(32'h28); chk(rd, 32'h0003_BC00);
		// magnitude above target lowers the gain
		sel <= 1'b1;
		fb_send(16'h4000, 16'h4000);
		chk_near({20'h0, mag}, 1192, 2);
		ahb_rd(32'h28); chk_near(rd, 32'h0003_B228, 32);
		sel <= 1'b0;
		// upper limit pulls the accumulator down
		ahb_wr(32'h24, 32'h0001_0000);
		ahb_rd(32'h28); chk(rd, 32'h0000_0100);
		fwd_t(26'h010_0000, 26'h3F0_0000, 0, 256);
		$display("loop done");
		test_done();
	end
endmodule
